/* tcm_ctrl_pkg.sv */
// constants, types and field layout for the tightly-coupled sram controller
// assumes a single 200 MHz core clock and an axi4-lite register master
//
// Functional notes
// - each tcm size is zero or a power of two up to one megabyte
// - instruction and data tcm sizes are programmed independently
// - both tcms are synchronous srams returning read data in one cycle
// - instruction and data addresses are multiplexed onto the instruction tcm
// - instruction tcm read data goes to both core read buses
// - instruction tcm sits at address zero, selected by plain decode
// - instruction tcm enabled: fetches and data accesses in range use it
// - instruction tcm disabled: fetches in its range go to the system bus
// - disabling a tcm leaves its contents untouched
// - tcm accesses stall only when a fetch yields the instruction tcm to data; system bus accesses may stall several cycles
// - instruction load mode sends reads in range to the bus
// - writes to the instruction tcm range ignore load mode
// - mask 0xC0000 sets instruction tcm enable and its load mode together
// - swap in load mode: read from bus, write into the tcm
// - data tcm enable bit 16 routes its range to the data tcm
// - data load mode, mask 0x30000, sends reads to the bus, not writes
package tcm_ctrl_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ISIZE = 8'h04;
  localparam logic [7:0] OFS_DBASE = 8'h08;
  localparam logic [7:0] OFS_DSIZE = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // control register bit positions
  localparam int BIT_DEN = 16;
  localparam int BIT_DLOAD = 17;
  localparam int BIT_IEN = 18;
  localparam int BIT_ILOAD = 19;

  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [4:0] SIZE_RST = 5'h00;
  localparam logic [31:0] DBASE_RST = 32'h0010_0000;
  localparam logic [31:0] IBASE = 32'h0000_0000;

  // size codes: 0 means no memory, n means 2**n bytes
  localparam logic [4:0] SIZE_MAX = 5'h14;
  localparam int MEM_AW = 18;
  localparam int MEM_WORDS = 1 << MEM_AW;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_INSTR = 2'b01,
    BUS_DATA = 2'b10
  } bus_state_t;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [4:0] isize;
    logic [31:0] dbase;
    logic [4:0] dsize;
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic i_valid;
    logic [31:0] i_rdata;
    logic d_valid;
    logic [31:0] d_rdata;
    bus_state_t bus;
    logic bus_req;
    logic bus_we;
    logic bus_instr;
    logic [31:0] bus_addr;
    logic [31:0] bus_wdata;
    logic [3:0] bus_be;
  } state_t;

endpackage : tcm_ctrl_pkg

/* sram_port_if.sv */
// one synchronous sram port shared between the controller and a memory
// assumes both ends run on the core clock
`timescale 1ns/100ps
`default_nettype none
interface sram_port_if;
  import tcm_ctrl_pkg::*;
  logic cs;
  logic we;
  logic [3:0] be;
  logic [MEM_AW-1:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport ctl (output cs, output we, output be, output addr, output wdata, input rdata);
  modport mem (input cs, input we, input be, input addr, input wdata, output rdata);
endinterface : sram_port_if
`default_nettype wire

/* tcm_sram.sv */
// word-wide sram array with byte write enables
// assumes the caller registers the read word at the next clock edge
`timescale 1ns/100ps
`default_nettype none
module tcm_sram
  import tcm_ctrl_pkg::*;
(
  input wire logic aclk,
  sram_port_if.mem port
);

  logic [31:0] mem_q [MEM_WORDS];

  ////////////////////////////////////////////////////////////////////////////
  // read word for the current address, captured by the controller
  assign port.rdata = mem_q[port.addr];

  // byte-lane writes; nothing else touches the array
  always_ff @(posedge aclk) begin
    for (int b = 0; b < 4; b++) begin
      if (port.cs && port.we && port.be[b]) begin
        mem_q[port.addr][8*b +: 8] <= port.wdata[8*b +: 8];
      end
    end
  end

endmodule : tcm_sram
`default_nettype wire

/* tightly_coupled_sram_control.sv */
// instruction and data tcm controller with system bus forwarding
// assumes core requests held until their valid, one system bus slave port
`timescale 1ns/100ps
`default_nettype none
module tightly_coupled_sram_control
  import tcm_ctrl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite register port
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // core instruction side
  input wire logic i_req,
  input wire logic [31:0] i_addr,
  output logic i_valid,
  output logic [31:0] i_rdata,
  // core data side
  input wire logic d_req,
  input wire logic d_we,
  input wire logic [3:0] d_be,
  input wire logic [31:0] d_addr,
  input wire logic [31:0] d_wdata,
  output logic d_valid,
  output logic [31:0] d_rdata,
  // system bus
  output logic bus_req,
  output logic bus_we,
  output logic bus_instr,
  output logic [31:0] bus_addr,
  output logic [31:0] bus_wdata,
  output logic [3:0] bus_be,
  input wire logic bus_ready,
  input wire logic [31:0] bus_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // address falls inside a region of 2**size bytes at base
  function automatic logic in_range(input logic [31:0] a, input logic [31:0] base,
                                    input logic [4:0] size);
    logic [31:0] mask;
    mask = 32'hFFFF_FFFF << size;
    in_range = (size != 5'h00) && ((a & mask) == (base & mask));
  endfunction : in_range

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    merge = r;
  endfunction : merge

  // size code written by software, held within the supported range
  function automatic logic [4:0] clamp_size(input logic [31:0] w);
    clamp_size = (w[31:5] != 27'h0 || w[4:0] > SIZE_MAX) ? SIZE_MAX : w[4:0];
  endfunction : clamp_size

  ////////////////////////////////////////////////////////////////////////////
  // memories

  sram_port_if itcm_port ();
  sram_port_if dtcm_port ();

  tcm_sram u_itcm (
    .aclk(aclk),
    .port(itcm_port)
  );

  tcm_sram u_dtcm (
    .aclk(aclk),
    .port(dtcm_port)
  );

  state_t s_q;
  state_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // routing decisions

  logic i_en;
  logic i_load;
  logic d_en;
  logic d_load;
  logic i_take;
  logic d_take;
  logic i_in_itcm;
  logic d_in_itcm;
  logic d_in_dtcm;
  logic i_tcm_go;
  logic d_itcm_go;
  logic d_dtcm_go;
  logic d_bus_go;
  logic i_bus_go;
  logic bus_done;

  // enable and load-mode bits steer every access
  assign i_en = s_q.ctrl[BIT_IEN];
  assign i_load = s_q.ctrl[BIT_ILOAD];
  assign d_en = s_q.ctrl[BIT_DEN];
  assign d_load = s_q.ctrl[BIT_DLOAD];

  // a held request is taken once, and not again in its answer cycle
  assign i_take = i_req && !s_q.i_valid && !(s_q.bus == BUS_INSTR);
  assign d_take = d_req && !s_q.d_valid && !(s_q.bus == BUS_DATA);

  // fixed-base decode for the instruction tcm, programmable for data
  assign i_in_itcm = in_range(i_addr, IBASE, s_q.isize);
  assign d_in_itcm = in_range(d_addr, IBASE, s_q.isize);
  assign d_in_dtcm = in_range(d_addr, s_q.dbase, s_q.dsize);

  // data side: tcm for writes always, for reads only outside load mode
  assign d_itcm_go = d_take && i_en && d_in_itcm && (d_we || !i_load);
  assign d_dtcm_go = d_take && !d_itcm_go && !d_in_itcm && d_en && d_in_dtcm
                     && (d_we || !d_load);
  assign d_bus_go = d_take && !d_itcm_go && !d_dtcm_go && (s_q.bus == BUS_IDLE);

  // instruction side yields the shared tcm port to data in the same cycle
  assign i_tcm_go = i_take && i_en && !i_load && i_in_itcm && !d_itcm_go;
  assign i_bus_go = i_take && !(i_en && !i_load && i_in_itcm) && !d_bus_go
                    && (s_q.bus == BUS_IDLE);

  assign bus_done = s_q.bus_req && bus_ready;

  ////////////////////////////////////////////////////////////////////////////
  // tcm ports

  // data address wins the instruction tcm mux when both want it
  always_comb begin
    itcm_port.cs = d_itcm_go || i_tcm_go;
    itcm_port.we = d_itcm_go && d_we;
    itcm_port.be = d_be;
    itcm_port.addr = d_itcm_go ? d_addr[MEM_AW+1:2] : i_addr[MEM_AW+1:2];
    itcm_port.wdata = d_wdata;
    dtcm_port.cs = d_dtcm_go;
    dtcm_port.we = d_dtcm_go && d_we;
    dtcm_port.be = d_be;
    dtcm_port.addr = d_addr[MEM_AW+1:2];
    dtcm_port.wdata = d_wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_d = s_q;

    // answers last one cycle
    s_d.i_valid = 1'b0;
    s_d.d_valid = 1'b0;

    // tcm hits answer at the next edge with no stall
    if (i_tcm_go) begin
      s_d.i_valid = 1'b1;
      s_d.i_rdata = itcm_port.rdata;
    end
    if (d_itcm_go) begin
      s_d.d_valid = 1'b1;
      s_d.d_rdata = itcm_port.rdata;
    end
    if (d_dtcm_go) begin
      s_d.d_valid = 1'b1;
      s_d.d_rdata = dtcm_port.rdata;
    end

    // system bus: one transfer at a time, data before instruction
    unique case (s_q.bus)
      BUS_IDLE: begin
        if (d_bus_go) begin
          s_d.bus = BUS_DATA;
          s_d.bus_req = 1'b1;
          s_d.bus_instr = 1'b0;
          s_d.bus_we = d_we;
          s_d.bus_addr = d_addr;
          s_d.bus_wdata = d_wdata;
          s_d.bus_be = d_be;
        end else if (i_bus_go) begin
          s_d.bus = BUS_INSTR;
          s_d.bus_req = 1'b1;
          s_d.bus_instr = 1'b1;
          s_d.bus_we = 1'b0;
          s_d.bus_addr = i_addr;
          s_d.bus_be = 4'hF;
        end
      end
      BUS_INSTR: begin
        if (bus_done) begin
          s_d.bus = BUS_IDLE;
          s_d.bus_req = 1'b0;
          s_d.i_valid = 1'b1;
          s_d.i_rdata = bus_rdata;
        end
      end
      BUS_DATA: begin
        if (bus_done) begin
          s_d.bus = BUS_IDLE;
          s_d.bus_req = 1'b0;
          s_d.d_valid = 1'b1;
          s_d.d_rdata = bus_rdata;
        end
      end
      default: begin
        s_d.bus = BUS_IDLE;
        s_d.bus_req = 1'b0;
      end
    endcase

    // axi write address and data, taken in either order
    if (s_q.awready && s_axi_awvalid) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_q.wready && s_axi_wvalid) begin
      s_d.w_have = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_q.aw_have && s_q.w_have) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      unique case (s_q.awaddr)
        OFS_CTRL: s_d.ctrl = merge(s_q.ctrl, s_q.wdata, s_q.wstrb);
        OFS_ISIZE: s_d.isize = clamp_size(merge({27'h0, s_q.isize}, s_q.wdata, s_q.wstrb));
        OFS_DBASE: s_d.dbase = merge(s_q.dbase, s_q.wdata, s_q.wstrb);
        OFS_DSIZE: s_d.dsize = clamp_size(merge({27'h0, s_q.dsize}, s_q.wdata, s_q.wstrb));
        OFS_STATUS: s_d.bresp = RESP_OKAY;
        default: s_d.bresp = RESP_DECERR;
      endcase
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    s_d.awready = !s_d.aw_have && !s_d.bvalid;
    s_d.wready = !s_d.w_have && !s_d.bvalid;

    // axi read: one beat answered the cycle after acceptance
    if (s_q.arready && s_axi_arvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_CTRL: s_d.rdata = s_q.ctrl;
        OFS_ISIZE: s_d.rdata = {27'h0, s_q.isize};
        OFS_DBASE: s_d.rdata = s_q.dbase;
        OFS_DSIZE: s_d.rdata = {27'h0, s_q.dsize};
        OFS_STATUS: s_d.rdata = {28'h0, s_q.bus_req, s_q.bus == BUS_DATA,
                                 s_q.bus == BUS_INSTR, s_q.bus != BUS_IDLE};
        default: begin
          s_d.rdata = 32'h0000_0000;
          s_d.rresp = RESP_DECERR;
        end
      endcase
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    s_d.arready = !s_d.rvalid;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; tcm arrays have no reset and keep their words

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.ctrl <= CTRL_RST;
      s_q.isize <= SIZE_RST;
      s_q.dsize <= SIZE_RST;
      s_q.dbase <= DBASE_RST;
      s_q.bus <= BUS_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign i_valid = s_q.i_valid;
  assign i_rdata = s_q.i_rdata;
  assign d_valid = s_q.d_valid;
  assign d_rdata = s_q.d_rdata;
  assign bus_req = s_q.bus_req;
  assign bus_we = s_q.bus_we;
  assign bus_instr = s_q.bus_instr;
  assign bus_addr = s_q.bus_addr;
  assign bus_wdata = s_q.bus_wdata;
  assign bus_be = s_q.bus_be;

endmodule : tightly_coupled_sram_control
`default_nettype wire

/* tcm_ctrl_monitor.sv */
// port assertions for the tcm controller
// assumes binding onto tightly_coupled_sram_control
`timescale 1ns/100ps
`default_nettype none
module tcm_ctrl_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic i_valid,
  input wire logic [31:0] i_rdata,
  input wire logic d_valid,
  input wire logic [31:0] d_rdata,
  input wire logic bus_req,
  input wire logic bus_we,
  input wire logic bus_instr,
  input wire logic [31:0] bus_addr,
  input wire logic bus_ready,
  input wire logic [31:0] bus_rdata
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////
  // core answers
  AST_I_PULSE: assert property (i_valid |=> !i_valid)
    else $error("i_valid held too long");
  AST_D_PULSE: assert property (d_valid |=> !d_valid)
    else $error("d_valid held too long");
  // system bus transfers
  AST_BUS_HOLD: assert property (bus_req && !bus_ready |=> bus_req && $stable(bus_addr))
    else $error("bus request dropped early");
  AST_BUS_DROP: assert property ($fell(bus_req) |-> $past(bus_ready))
    else $error("bus request fell without ready");
  AST_D_BUS: assert property (bus_req && bus_ready && !bus_we && !bus_instr
    |=> d_valid && d_rdata == $past(bus_rdata))
    else $error("data read from bus not returned");
  AST_I_BUS: assert property (bus_req && bus_ready && bus_instr
    |=> i_valid && i_rdata == $past(bus_rdata))
    else $error("fetch from bus not returned");
  AST_W_BUS: assert property (bus_req && bus_ready && bus_we |=> d_valid)
    else $error("bus write not acknowledged");
  // register port
  AST_R_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("register read not answered");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
endmodule : tcm_ctrl_monitor
bind tightly_coupled_sram_control tcm_ctrl_monitor mon_u (.*);
`default_nettype wire

/* bus_slave_model.sv */
// system bus slave standing in for external memory
// assumes the controller holds each request until bus_ready
`timescale 1ns/100ps
`default_nettype none
module bus_slave_model (
  input wire logic aclk,
  input wire logic bus_req,
  input wire logic bus_we,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic [3:0] bus_be,
  input wire logic [3:0] stall,
  output logic bus_ready,
  output logic [31:0] bus_rdata,
  output logic [15:0] xfers
);
  logic [31:0] mem [logic [29:0]];
  logic [31:0] w;
  logic [3:0] cnt;
  initial begin
    bus_ready = 1'b0;
    bus_rdata = 32'h0;
    xfers = 16'h0;
    cnt = 4'h0;
  end
  ////////////////////////////////////////////////////////////////////////
  // answer after stall cycles; data line scrambled when idle
  always @(posedge aclk) begin
    bus_ready <= 1'b0;
    bus_rdata <= ~bus_rdata;
    if (bus_req && !bus_ready) begin
      cnt <= cnt + 4'h1;
      if (cnt >= stall) begin
        cnt <= 4'h0;
        bus_ready <= 1'b1;
        xfers <= xfers + 16'h1;
        w = mem.exists(bus_addr[31:2]) ? mem[bus_addr[31:2]] : bus_addr ^ 32'hA5A5_5A5A;
        if (!bus_we) bus_rdata <= w;
        for (int b = 0; b < 4; b++) if (bus_be[b]) w[8*b+:8] = bus_wdata[8*b+:8];
        if (bus_we) mem[bus_addr[31:2]] = w;
      end
    end
  end
endmodule : bus_slave_model
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the tcm controller
// assumes bus_slave_model as external memory
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import tcm_ctrl_pkg::*;
  typedef struct {logic [31:0] c; logic s; logic we; logic [31:0] a, wd, x; logic e;} row_t;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, i_addr, i_rdata, d_addr, d_wdata, d_rdata;
  logic [31:0] bus_addr, bus_wdata, bus_rdata, q, q2, prev;
  logic [3:0] s_axi_wstrb, d_be, bus_be, stall;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic i_req, i_valid, d_req, d_we, d_valid, bus_req, bus_we, bus_instr, bus_ready;
  logic [15:0] xfers, x0;
  int num_errors, samples_checked, lat, lat2, b_wait;
  row_t rows [13] = '{
    '{32'h4_0000, 0, 1, 32'h100, 32'h1111_1111, 0, 0}, '{32'h4_0000, 1, 0, 32'h100, 0, 32'h1111_1111, 0},
    '{32'h4_0000, 0, 0, 32'h100, 0, 32'h1111_1111, 0}, '{32'h0, 1, 0, 32'h100, 0, 0, 1},
    '{32'hC_0000, 0, 0, 32'h104, 0, 0, 1}, '{32'hC_0000, 0, 1, 32'h104, 32'h2222, 0, 0},
    '{32'h4_0000, 0, 0, 32'h104, 0, 32'h2222, 0}, '{32'h4_0000, 0, 0, 32'h1000, 0, 0, 1},
    '{32'h1_0000, 0, 1, 32'h10_0010, 32'h3333, 0, 0}, '{32'h3_0000, 0, 0, 32'h10_0010, 0, 0, 1},
    '{32'h3_0000, 0, 1, 32'h10_0014, 32'h4444, 0, 0}, '{32'h1_0000, 0, 0, 32'h10_0014, 0, 32'h4444, 0},
    '{32'h0, 0, 0, 32'h10_0010, 0, 0, 1}};
  tightly_coupled_sram_control dut_u (.*);
  bus_slave_model slave_u (.aclk(aclk), .bus_req(bus_req), .bus_we(bus_we), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_be(bus_be), .stall(stall), .bus_ready(bus_ready),
    .bus_rdata(bus_rdata), .xfers(xfers));
  ////////////////////////////////////////////////////////////////////////
  // clock and helpers
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", n, exp, seen);
    end
  endtask : check
  task automatic stop_test;
    if (num_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test
  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset
  // register write, both channels offered together
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (b_wait == 0);
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
      if (n >= b_wait) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
    s_axi_bready <= 1'b0;
    check("b_wait", 32'(n < 50), 32'h1);
    check("bresp", 32'(s_axi_bresp), 32'(er));
  endtask : wr
  // register read
  task automatic rd(logic [7:0] a, logic [31:0] ed, logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b0;
    check("r_wait", 32'(n < 50), 32'h1);
    check("rdata", s_axi_rdata, ed);
    check("rresp", 32'(s_axi_rresp), 32'(er));
  endtask : rd
  // one core access; side 1 fetches, side 0 is the data port
  task automatic core(logic s, logic we, logic [31:0] a, logic [31:0] wd,
                      output logic [31:0] r, output int l);
    @(posedge aclk);
    if (s) begin
      i_req <= 1'b1;
      i_addr <= a;
    end else begin
      d_req <= 1'b1;
      d_we <= we;
      d_addr <= a;
      d_wdata <= wd;
    end
    l = 0;
    do begin
      @(posedge aclk);
      l++;
    end while (!(s ? i_valid : d_valid) && l < 200);
    if (s) i_req <= 1'b0;
    else d_req <= 1'b0;
    r = s ? i_rdata : d_rdata;
    check("core_wait", 32'(l < 200), 32'h1);
  endtask : core
  ////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    repeat (30000) @(posedge aclk);
    num_errors++;
    stop_test();
  end
  // main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    {i_req, d_req, d_we, i_addr, d_addr, d_wdata} = 99'h0;
    d_be = 4'hF;
    stall = 4'h1;
    prev = 32'h0;
    do_reset();
    wr(OFS_ISIZE, 32'h0C, RESP_OKAY);
    wr(OFS_DSIZE, 32'h0C, RESP_OKAY);
    // tcm filled before fetching from it; load mode reads from the bus and writes into it
    foreach (rows[k]) begin
      rd(OFS_CTRL, prev, RESP_OKAY);
      prev = (prev & ~32'h000F_0000) | rows[k].c;
      wr(OFS_CTRL, prev, RESP_OKAY);
      x0 = xfers;
      core(rows[k].s, rows[k].we, rows[k].a, rows[k].wd, q, lat);
      if (!rows[k].we)
        check("data", q, rows[k].e ? rows[k].a ^ 32'hA5A5_5A5A : rows[k].x);
      check("bus_xfers", 32'(xfers - x0), 32'(rows[k].e));
      if (!rows[k].e) check("latency", lat, 2);
    end
    // both sides on the instruction tcm at once
    wr(OFS_CTRL, 32'h4_0000, RESP_OKAY);
    fork
      core(1'b1, 1'b0, 32'h100, 32'h0, q, lat);
      core(1'b0, 1'b0, 32'h104, 32'h0, q2, lat2);
    join
    check("i_conflict", q, 32'h1111_1111);
    check("d_conflict", q2, 32'h2222);
    // load-mode copy: load from bus, store to the same address
    wr(OFS_CTRL, 32'hC_0000, RESP_OKAY);
    stall <= 4'h6;
    core(1'b0, 1'b0, 32'h108, 32'h0, q, lat);
    check("slow_bus", q, 32'h108 ^ 32'hA5A5_5A5A);
    check("stalled", 32'(lat > 7), 32'h1);
    core(1'b0, 1'b1, 32'h108, q, q2, lat);
    wr(OFS_CTRL, 32'h4_0000, RESP_OKAY);
    core(1'b1, 1'b0, 32'h108, 32'h0, q2, lat);
    check("copied", q2, q);
    // size clamp and zero size
    wr(OFS_ISIZE, 32'h1F, RESP_OKAY);
    rd(OFS_ISIZE, 32'h14, RESP_OKAY);
    rd(OFS_DSIZE, 32'h0C, RESP_OKAY);
    wr(OFS_ISIZE, 32'h00, RESP_OKAY);
    core(1'b1, 1'b0, 32'h100, 32'h0, q, lat);
    check("no_itcm", q, 32'h100 ^ 32'hA5A5_5A5A);
    // moved data tcm with a late bready, bus write with lanes, status idle
    b_wait = 3;
    wr(OFS_DBASE, 32'h0020_0000, RESP_OKAY);
    b_wait = 0;
    wr(OFS_CTRL, 32'h1_0000, RESP_OKAY);
    core(1'b0, 1'b0, 32'h20_0014, 32'h0, q, lat);
    check("dtcm_moved", q, 32'h4444);
    core(1'b0, 1'b0, 32'h10_0014, 32'h0, q, lat);
    check("dtcm_old", q, 32'h10_0014 ^ 32'hA5A5_5A5A);
    core(1'b0, 1'b1, 32'h2000, 32'h5A5A_0001, q, lat);
    d_be <= 4'h1;
    core(1'b0, 1'b1, 32'h2000, 32'hFFFF_FFFF, q, lat);
    d_be <= 4'hF;
    core(1'b0, 1'b0, 32'h2000, 32'h0, q, lat);
    check("bus_wr", q, 32'h5A5A_00FF);
    rd(OFS_STATUS, 32'h0, RESP_OKAY);
    wr(8'h20, 32'h1, RESP_DECERR);
    rd(8'h20, 32'h0, RESP_DECERR);
    // second reset: registers back to reset values, contents kept
    do_reset();
    rd(OFS_CTRL, CTRL_RST, RESP_OKAY);
    rd(OFS_ISIZE, 32'(SIZE_RST), RESP_OKAY);
    rd(OFS_DBASE, DBASE_RST, RESP_OKAY);
    rd(OFS_DSIZE, 32'(SIZE_RST), RESP_OKAY);
    wr(OFS_ISIZE, 32'h0C, RESP_OKAY);
    wr(OFS_CTRL, 32'h4_0000, RESP_OKAY);
    core(1'b0, 1'b0, 32'h100, 32'h0, q, lat);
    check("kept", q, 32'h1111_1111);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
